/* core/lsm_display.sv */
// Overview of operation
// - Bus menu level one: linked nodes green, unlinked red, own node linked.
// - Bus menu level two: memory flags high green, low red, unconfigured dark.
// - Bus menu level three: LED 1, 2 or 3 green for 125k, 250k, 500k.
// - Fatal error turns outputs off, stops communication, shows error pattern.
// - Fatal error: all six menu LEDs red plus code LEDs red.
// - Codes: no identity 0x0002, bad serial 0x0009, bad node 0x000F.
// - Output overcurrent enters fatal error with code 0x000A.
// - Supply over limit 0x0100, under limit 0x0102.
// - User fatal codes 0xC001 to 0xC0FF on LEDs 15, 16, 1-8.
// - Configuration mode: six menu LEDs and LED 1 orange.
// - Level one: menu LED green, short press selects next menu.
// - One second hold goes one level deeper, wrapping to level one.
// - Level two: menu LED red, short press selects next node.
// - Only voltage and bus menus have level three, menu LED orange.
// - Touch released under one second is a short press only.
// - Reset and long idleness select node menu at level one.
//
// The register addresses and register access over APB were left to the implementer.
module lsm_display
	import lsm_pkg::*;
#(
	parameter longint DEB_CYC  = DEB_CYC_DEF,
	parameter longint LONG_CYC = LONG_CYC_DEF,
	parameter longint IDLE_CYC = IDLE_CYC_DEF
)(
	input  wire logic        SYS_CLK,
	input  wire logic        ARST_N,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic        BUTTON,
	input  wire logic [15:0] NODE_LINK,
	input  wire logic [15:0] MEM_CFG,
	input  wire logic [15:0] MEM_VAL,
	input  wire logic [1:0]  BUS_RATE,
	input  wire logic        MISSING_NET_IDENTITY,
	input  wire logic        BAD_SERIAL_SETTINGS,
	input  wire logic        OUTPUT_OVERCURRENT_FAULT,
	input  wire logic        BAD_NODE_NUMBER,
	input  wire logic        SUPPLY_OVER_LIMIT,
	input  wire logic        SUPPLY_UNDER_LIMIT,
	output logic      [5:0]  MENU_RED,
	output logic      [5:0]  MENU_GREEN,
	output logic      [15:0] NUM_RED,
	output logic      [15:0] NUM_GREEN,
	output logic             IO_OFF,
	output logic             COMM_STOP,
	output logic             IRQ
);

	logic            rdy_q, err_q, acc, wr, user_raise, fault_any;
	logic [31:0]     rdata_q, rd_d;
	logic [3:0]      node_q, sel_q, stat_q, mask_q, ev, clr;
	logic            cfg_q, fatal_q, io_off_q, comm_q, irq_q, lock;
	logic [15:0]     code_q, code_d, own, links;
	logic [32:0]     idle_q;
	logic            touch, short_p, long_p, idle_hit;
	lsm_menu_e       menu_q;
	lsm_lvl_t        lvl_q;
	lsm_led_s        disp_q, disp_d;

	function automatic logic mapped(input logic [7:0] a);
		return a == A_CTRL || a == A_USER_ERR || a == A_STATUS ||
			a == A_CODE || a == A_INT_STAT || a == A_INT_MASK;
	endfunction : mapped

	// ****************************************************************
	// APB slave
	// ****************************************************************
	assign acc = PSEL && PENABLE && !rdy_q;
	assign wr  = PSEL && PENABLE && rdy_q && PWRITE;

	always_comb
	begin
		rd_d = '0;
		if (PADDR == A_CTRL)
		begin
			rd_d[3:0]      = node_q;
			rd_d[CTRL_CFG] = cfg_q;
		end
		else if (PADDR == A_STATUS)
		begin
			rd_d[2:0]            = menu_q;
			rd_d[ST_LVL +: 2]    = lvl_q;
			rd_d[ST_SEL +: 4]    = sel_q;
			rd_d[ST_FATAL]       = fatal_q;
		end
		else if (PADDR == A_CODE)
			rd_d[15:0] = code_q;
		else if (PADDR == A_INT_STAT)
			rd_d[NIRQ-1:0] = stat_q;
		else if (PADDR == A_INT_MASK)
			rd_d[NIRQ-1:0] = mask_q;
	end

	always_ff @(posedge SYS_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			rdy_q   <= 1'b0;
			err_q   <= 1'b0;
			rdata_q <= '0;
		end
		else
		begin
			rdy_q   <= acc;
			err_q   <= acc && !mapped(PADDR);
			rdata_q <= (acc && !PWRITE) ? rd_d : 32'h0000_0000;
		end
	end

	always_ff @(posedge SYS_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			node_q <= NODE_RST;
			cfg_q  <= 1'b0;
			mask_q <= MASK_RST;
		end
		else if (wr && PADDR == A_CTRL)
		begin
			node_q <= PWDATA[3:0];
			cfg_q  <= PWDATA[CTRL_CFG];
		end
		else if (wr && PADDR == A_INT_MASK)
			mask_q <= PWDATA[NIRQ-1:0];
	end

	assign user_raise = wr && PADDR == A_USER_ERR && PWDATA[7:0] != 8'h00;

	// ****************************************************************
	// Button and idle return
	// ****************************************************************
	lsm_press #(
		.DEB_CYC  (DEB_CYC),
		.LONG_CYC (LONG_CYC)
	) u_press (
		.clk     (SYS_CLK),
		.arst_n  (ARST_N),
		.btn     (BUTTON),
		.touch   (touch),
		.short_p (short_p),
		.long_p  (long_p)
	);

	always_ff @(posedge SYS_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			idle_q <= '0;
		else if (touch)
			idle_q <= '0;
		else if (idle_q != IDLE_CYC[32:0])
			idle_q <= idle_q + 33'd1;
	end

	assign idle_hit = !touch && idle_q == IDLE_CYC[32:0] - 33'd1;

	// ****************************************************************
	// Menu navigation
	// ****************************************************************
	assign lock = fatal_q || cfg_q;

	always_ff @(posedge SYS_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			menu_q <= MN_NODE;
			lvl_q  <= 2'd0;
			sel_q  <= 4'h0;
		end
		else if (idle_hit)
		begin
			menu_q <= MN_NODE;
			lvl_q  <= 2'd0;
			sel_q  <= 4'h0;
		end
		else if (!lock && long_p)
			lvl_q <= (lvl_q == lsm_lvl_max(menu_q)) ? 2'd0 : lvl_q + 2'd1;
		else if (!lock && short_p)
		begin
			if (lvl_q == 2'd0)
			begin
				case (menu_q)
					MN_NODE:  menu_q <= MN_IO;
					MN_IO:    menu_q <= MN_VOLT;
					MN_VOLT:  menu_q <= MN_MEM;
					MN_MEM:   menu_q <= MN_RADIO;
					MN_RADIO: menu_q <= MN_BUS;
					default:  menu_q <= MN_NODE;
				endcase
			end
			else
				sel_q <= sel_q + 4'h1;
		end
	end

	// ****************************************************************
	// Fatal error capture
	// ****************************************************************
	always_comb
	begin
		fault_any = 1'b1;
		code_d    = 16'h0000;
		if (MISSING_NET_IDENTITY)
			code_d = C_NO_ID;
		else if (BAD_SERIAL_SETTINGS)
			code_d = C_SERIAL;
		else if (OUTPUT_OVERCURRENT_FAULT)
			code_d = C_OVERCUR;
		else if (BAD_NODE_NUMBER)
			code_d = C_NODE;
		else if (SUPPLY_OVER_LIMIT)
			code_d = C_HIGH;
		else if (SUPPLY_UNDER_LIMIT)
			code_d = C_LOW;
		else if (user_raise)
			code_d = {C_USER_HI, PWDATA[7:0]};
		else
			fault_any = 1'b0;
	end

	always_ff @(posedge SYS_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			fatal_q  <= 1'b0;
			code_q   <= '0;
			io_off_q <= 1'b0;
			comm_q   <= 1'b0;
		end
		else
		begin
			io_off_q <= fatal_q;
			comm_q   <= fatal_q;
			if (!fatal_q && fault_any)
			begin
				fatal_q <= 1'b1;
				code_q  <= code_d;
			end
		end
	end

	// ****************************************************************
	// Display
	// ****************************************************************
	assign own   = lsm_onehot(node_q);
	assign links = NODE_LINK | own;

	always_comb
	begin
		disp_d = '0;
		if (fatal_q)
		begin
			disp_d.menu_r = 6'h3F;
			disp_d.num_r  = code_q;
		end
		else if (cfg_q)
		begin
			disp_d.menu_r = 6'h3F;
			disp_d.menu_g = 6'h3F;
			disp_d.num_r  = 16'h0001;
			disp_d.num_g  = 16'h0001;
		end
		else
		begin
			disp_d.menu_g[menu_q] = lvl_q != 2'd1;
			disp_d.menu_r[menu_q] = lvl_q != 2'd0;
			case (menu_q)
				MN_NODE:
				begin
					if (lvl_q == 2'd0)
						disp_d.num_g = own;
					else
					begin
						disp_d.num_g = links;
						disp_d.num_r = ~links;
					end
				end
				MN_BUS:
				begin
					if (lvl_q == 2'd0)
					begin
						disp_d.num_g = links;
						disp_d.num_r = ~links;
					end
					else if (lvl_q == 2'd1)
					begin
						disp_d.num_g = MEM_CFG & MEM_VAL;
						disp_d.num_r = MEM_CFG & ~MEM_VAL;
					end
					else if (BUS_RATE != 2'd3)
						disp_d.num_g = lsm_onehot({2'b00, BUS_RATE});
				end
				default:
				begin
					if (lvl_q != 2'd0)
						disp_d.num_g = lsm_onehot(sel_q);
				end
			endcase
		end
	end

	always_ff @(posedge SYS_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			disp_q <= '0;
		else
			disp_q <= disp_d;
	end

	// ****************************************************************
	// Interrupts
	// ****************************************************************
	assign ev[IRQ_SHORT] = short_p && !lock;
	assign ev[IRQ_LONG]  = long_p && !lock;
	assign ev[IRQ_FATAL] = !fatal_q && fault_any;
	assign ev[IRQ_IDLE]  = idle_hit;
	assign clr = (wr && PADDR == A_INT_STAT) ? PWDATA[NIRQ-1:0] : 4'h0;

	always_ff @(posedge SYS_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			stat_q <= '0;
			irq_q  <= 1'b0;
		end
		else
		begin
			stat_q <= (stat_q & ~clr) | ev;
			irq_q  <= |(stat_q & mask_q);
		end
	end

	assign PRDATA     = rdata_q;
	assign PREADY     = rdy_q;
	assign PSLVERR    = err_q;
	assign MENU_RED   = disp_q.menu_r;
	assign MENU_GREEN = disp_q.menu_g;
	assign NUM_RED    = disp_q.num_r;
	assign NUM_GREEN  = disp_q.num_g;
	assign IO_OFF     = io_off_q;
	assign COMM_STOP  = comm_q;
	assign IRQ        = irq_q;

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (!ARST_N);

	property p_link_menu;
		!lock && menu_q == MN_BUS && lvl_q == 2'd0
		|=> NUM_GREEN == $past(links) && NUM_RED == ~$past(links);
	endproperty
	a_link_menu: assert property (p_link_menu)
		else $error("bus link display wrong");

	property p_mem_menu;
		!lock && menu_q == MN_BUS && lvl_q == 2'd1
		|=> NUM_GREEN == $past(MEM_CFG & MEM_VAL) && MENU_RED[5];
	endproperty
	a_mem_menu: assert property (p_mem_menu)
		else $error("bus memory display wrong");

	property p_rate;
		!lock && menu_q == MN_BUS && lvl_q == 2'd2 && BUS_RATE == 2'd2
		|=> NUM_GREEN == 16'h0004 && NUM_RED == 16'h0000;
	endproperty
	a_rate: assert property (p_rate)
		else $error("bit rate LED wrong");

	property p_fatal_off;
		$rose(fatal_q) |=> IO_OFF && COMM_STOP ##1 IO_OFF;
	endproperty
	a_fatal_off: assert property (p_fatal_off)
		else $error("outputs not off in fatal state");

	property p_fatal_show;
		fatal_q |=> MENU_RED == 6'h3F && MENU_GREEN == 6'h00 &&
			NUM_RED == $past(code_q);
	endproperty
	a_fatal_show: assert property (p_fatal_show)
		else $error("fatal pattern wrong");

	property p_overcur;
		!fatal_q && OUTPUT_OVERCURRENT_FAULT && !MISSING_NET_IDENTITY &&
			!BAD_SERIAL_SETTINGS |=> fatal_q && code_q == 16'h000A;
	endproperty
	a_overcur: assert property (p_overcur)
		else $error("overcurrent code wrong");

	property p_cfg;
		cfg_q && !fatal_q |=> MENU_RED == 6'h3F && MENU_GREEN == 6'h3F &&
			NUM_RED == 16'h0001 && NUM_GREEN == 16'h0001;
	endproperty
	a_cfg: assert property (p_cfg)
		else $error("configuration pattern wrong");

	property p_next_menu;
		short_p && !lock && lvl_q == 2'd0 && !idle_hit
		|=> menu_q != $past(menu_q) && lvl_q == 2'd0;
	endproperty
	a_next_menu: assert property (p_next_menu)
		else $error("short press did not change menu");

	property p_wrap;
		long_p && !lock && !idle_hit && lvl_q == lsm_lvl_max(menu_q)
		|=> lvl_q == 2'd0 ##1 MENU_GREEN != 6'h00;
	endproperty
	a_wrap: assert property (p_wrap)
		else $error("level did not wrap");

	property p_lock;
		lock && !idle_hit |=> $stable(menu_q) && $stable(lvl_q);
	endproperty
	a_lock: assert property (p_lock)
		else $error("menu moved while locked");

	property p_idle;
		idle_hit |=> menu_q == MN_NODE && lvl_q == 2'd0;
	endproperty
	a_idle: assert property (p_idle)
		else $error("idle return failed");

endmodule : lsm_display

/* core/lsm_pkg.sv */
package lsm_pkg;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam longint CLK_HZ        = 40_000_000;
	localparam longint DEB_MS        = 10;
	localparam longint LONG_PRESS_MS = 1000;
	localparam longint IDLE_S        = 120;
	localparam longint DEB_CYC_DEF   = CLK_HZ * DEB_MS / 1000;
	localparam longint LONG_CYC_DEF  = CLK_HZ * LONG_PRESS_MS / 1000;
	localparam longint IDLE_CYC_DEF  = CLK_HZ * IDLE_S;

	// ****************************************************************
	// Register map and fields
	// ****************************************************************
	localparam logic [7:0]  A_CTRL     = 8'h00;
	localparam logic [7:0]  A_USER_ERR = 8'h04;
	localparam logic [7:0]  A_STATUS   = 8'h08;
	localparam logic [7:0]  A_CODE     = 8'h0C;
	localparam logic [7:0]  A_INT_STAT = 8'h10;
	localparam logic [7:0]  A_INT_MASK = 8'h14;
	localparam int          CTRL_CFG   = 4;
	localparam int          ST_LVL     = 4;
	localparam int          ST_SEL     = 8;
	localparam int          ST_FATAL   = 16;
	localparam int          NIRQ       = 4;
	localparam int          IRQ_SHORT  = 0;
	localparam int          IRQ_LONG   = 1;
	localparam int          IRQ_FATAL  = 2;
	localparam int          IRQ_IDLE   = 3;
	localparam logic [3:0]  MASK_RST   = 4'h0;
	localparam logic [3:0]  NODE_RST   = 4'h0;

	// ****************************************************************
	// Fatal error codes
	// ****************************************************************
	localparam logic [15:0] C_NO_ID    = 16'h0002;
	localparam logic [15:0] C_SERIAL   = 16'h0009;
	localparam logic [15:0] C_OVERCUR  = 16'h000A;
	localparam logic [15:0] C_NODE     = 16'h000F;
	localparam logic [15:0] C_HIGH     = 16'h0100;
	localparam logic [15:0] C_LOW      = 16'h0102;
	localparam logic [7:0]  C_USER_HI  = 8'hC0;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [2:0] {
		MN_NODE, MN_IO, MN_VOLT, MN_MEM, MN_RADIO, MN_BUS
	} lsm_menu_e;

	typedef logic [1:0] lsm_lvl_t;

	typedef struct packed {
		logic [5:0]  menu_r;
		logic [5:0]  menu_g;
		logic [15:0] num_r;
		logic [15:0] num_g;
	} lsm_led_s;

	// Deepest level index of a menu.
	function automatic lsm_lvl_t lsm_lvl_max(input lsm_menu_e m);
		return (m == MN_VOLT || m == MN_BUS) ? 2'd2 : 2'd1;
	endfunction : lsm_lvl_max

	function automatic logic [15:0] lsm_onehot(input logic [3:0] i);
		return 16'h0001 << i;
	endfunction : lsm_onehot

endpackage : lsm_pkg

/* core/lsm_press.sv */
module lsm_press
	import lsm_pkg::*;
#(
	parameter longint DEB_CYC  = DEB_CYC_DEF,
	parameter longint LONG_CYC = LONG_CYC_DEF
)(
	input  wire logic clk,
	input  wire logic arst_n,
	input  wire logic btn,
	output logic      touch,
	output logic      short_p,
	output logic      long_p
);

	logic        s1_q, s2_q, touch_q, tprev_q, done_q, short_q, long_q;
	logic [31:0] deb_q;
	logic [31:0] hold_q;

	// ****************************************************************
	// Synchroniser and debounce
	// ****************************************************************
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
		end
		else
		begin
			s1_q <= btn;
			s2_q <= s1_q;
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			deb_q   <= '0;
			touch_q <= 1'b0;
		end
		else if (s2_q == touch_q)
			deb_q <= '0;
		else if (deb_q == DEB_CYC[31:0] - 32'd1)
		begin
			deb_q   <= '0;
			touch_q <= s2_q;
		end
		else
			deb_q <= deb_q + 32'd1;
	end

	// ****************************************************************
	// Press duration
	// ****************************************************************
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			hold_q  <= '0;
			done_q  <= 1'b0;
			tprev_q <= 1'b0;
			short_q <= 1'b0;
			long_q  <= 1'b0;
		end
		else
		begin
			tprev_q <= touch_q;
			long_q  <= touch_q && !done_q && hold_q == LONG_CYC[31:0] - 32'd1;
			short_q <= tprev_q && !touch_q && !done_q;
			if (!touch_q)
			begin
				hold_q <= '0;
				done_q <= 1'b0;
			end
			else if (!done_q)
			begin
				if (hold_q == LONG_CYC[31:0] - 32'd1)
					done_q <= 1'b1;
				else
					hold_q <= hold_q + 32'd1;
			end
		end
	end

	assign touch   = touch_q;
	assign short_p = short_q;
	assign long_p  = long_q;

	property p_short_once;
		@(posedge clk) disable iff (!arst_n)
		short_q |-> !long_q && !touch_q && $past(!done_q);
	endproperty
	a_short_once: assert property (p_short_once)
		else $error("short press after long press or while touched");

endmodule : lsm_press

/* testbench/lsm_operator.sv */
module lsm_operator
(
	input  wire logic SYS_CLK,
	input  wire logic press_req,
	input  wire logic [31:0] press_len,
	output logic      BUTTON,
	output logic      press_done
);
	timeunit 1ns;
	timeprecision 1ps;

	// ****************************************************************
	// Touch with contact chatter at both ends
	// ****************************************************************
	// A real finger chatters, so each touch starts and ends with
	// one-cycle glitches that the debouncer has to swallow.
	initial
	begin
		BUTTON = 1'b0;
		press_done = 1'b0;
		forever
		begin
			@(posedge SYS_CLK);
			if (press_req && !press_done)
			begin
				BUTTON <= 1'b1;
				@(posedge SYS_CLK) BUTTON <= 1'b0;
				@(posedge SYS_CLK) BUTTON <= 1'b1;
				repeat (press_len) @(posedge SYS_CLK);
				BUTTON <= 1'b0;
				@(posedge SYS_CLK) BUTTON <= 1'b1;
				@(posedge SYS_CLK) BUTTON <= 1'b0;
				repeat (16) @(posedge SYS_CLK);
				press_done <= 1'b1;
				@(posedge SYS_CLK);
				while (press_req) @(posedge SYS_CLK);
				press_done <= 1'b0;
			end
		end
	end
endmodule : lsm_operator

/* testbench/lsm_display_tb.sv */
module lsm_display_tb
	import lsm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic        sys_clk = 1'b0, arst_n = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata;
	logic        pready, pslverr, button, press_req = 1'b0, press_done;
	int          press_len = 0;
	logic [15:0] node_link = 16'h0000, mem_cfg = 16'h0000;
	logic [15:0] mem_val = 16'h0000;
	logic [1:0]  bus_rate = 2'h0;
	logic [5:0]  fault_v = 6'h00, menu_red, menu_green;
	logic [15:0] num_red, num_green;
	logic        io_off, comm_stop, irq;
	int          failures = 0, samples_checked = 0, cyc = 0;
	logic [31:0] r;
	logic        e;

	always #12.5 sys_clk = ~sys_clk;

	lsm_display #(.DEB_CYC(4), .LONG_CYC(50), .IDLE_CYC(2000)) DUT (
		.SYS_CLK(sys_clk), .ARST_N(arst_n), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
		.PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .BUTTON(button), .NODE_LINK(node_link),
		.MEM_CFG(mem_cfg), .MEM_VAL(mem_val), .BUS_RATE(bus_rate),
		.MISSING_NET_IDENTITY(fault_v[0]), .BAD_SERIAL_SETTINGS(fault_v[1]),
		.OUTPUT_OVERCURRENT_FAULT(fault_v[2]), .BAD_NODE_NUMBER(fault_v[3]),
		.SUPPLY_OVER_LIMIT(fault_v[4]), .SUPPLY_UNDER_LIMIT(fault_v[5]),
		.MENU_RED(menu_red), .MENU_GREEN(menu_green), .NUM_RED(num_red),
		.NUM_GREEN(num_green), .IO_OFF(io_off), .COMM_STOP(comm_stop),
		.IRQ(irq));

	lsm_operator op (.SYS_CLK(sys_clk), .press_req(press_req),
		.press_len(press_len), .BUTTON(button), .press_done(press_done));

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic wrap_up();
		$display("failures=%0d samples_checked=%0d", failures, samples_checked);
		if (failures == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : wrap_up

	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			failures++;
			wrap_up();
		end
	end

	task automatic chk(input logic [47:0] seen, input logic [47:0] exp,
		input string msg);
		samples_checked++;
		if (seen !== exp)
		begin
			failures++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1) @(posedge sys_clk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic press(input int len);
		press_len <= len;
		press_req <= 1'b1;
		@(posedge sys_clk);
		while (press_done !== 1'b1) @(posedge sys_clk);
		press_req <= 1'b0;
		@(posedge sys_clk);
	endtask : press

	task automatic do_reset();
		@(posedge sys_clk);
		arst_n <= 1'b0;
		repeat (10) @(posedge sys_clk);
		arst_n <= 1'b1;
		@(posedge sys_clk);
	endtask : do_reset

	function automatic logic [43:0] leds();
		return {menu_red, menu_green, num_red, num_green};
	endfunction : leds

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_reset_state();
		// The display registers load on the first edge after release.
		@(posedge sys_clk);
		chk(leds(), {6'h00, 6'h01, 16'h0000, 16'h0001}, "start");
		apb(0, A_STATUS, 0);
		chk(r, 32'h0000_0000, "status");
		apb(0, A_INT_MASK, 0);
		chk(r, {28'h000_0000, MASK_RST}, "mask");
		apb(0, A_CTRL, 0);
		chk(r, {28'h000_0000, NODE_RST}, "ctrl");
	endtask : t_reset_state

	task automatic t_menu_cycle();
		apb(1, A_INT_STAT, 32'h0000_000F);
		apb(1, A_INT_MASK, 32'h0000_0001);
		for (int i = 1; i <= 6; i++)
		begin
			press(20);
			chk({menu_red, menu_green}, {6'h00, 6'h01 << (i % 6)}, "menu");
		end
		apb(0, A_INT_STAT, 0);
		chk(r[1:0], 2'b01, "short only");
		chk(irq, 1'b1, "irq set");
		apb(1, A_INT_STAT, 32'h0000_0001);
		repeat (3) @(posedge sys_clk);
		chk(irq, 1'b0, "irq cleared");
		apb(1, A_INT_MASK, 32'h0000_0000);
	endtask : t_menu_cycle

	task automatic t_two_level();
		apb(1, A_INT_STAT, 32'h0000_000F);
		press(80);
		chk(leds(), {6'h01, 6'h00, 16'hFFFE, 16'h0001}, "level two");
		apb(0, A_INT_STAT, 0);
		chk(r[1:0], 2'b10, "long only");
		chk(irq, 1'b0, "masked");
		press(20);
		apb(0, A_STATUS, 0);
		chk({r[11:8], r[2:0]}, {4'h1, 3'h0}, "next node");
		press(80);
		chk({menu_red, menu_green}, {6'h00, 6'h01}, "wrap");
	endtask : t_two_level

	task automatic t_bus_menu();
		node_link <= 16'h0004;
		mem_cfg <= 16'h8003;
		mem_val <= 16'h8001;
		repeat (5) press(20);
		chk(leds(), {6'h00, 6'h20, 16'hFFFA, 16'h0005}, "links");
		apb(1, A_CTRL, 32'h0000_0003);
		repeat (3) @(posedge sys_clk);
		chk(leds(), {6'h00, 6'h20, 16'hFFF3, 16'h000C}, "own node");
		apb(1, A_CTRL, 32'h0000_0000);
		press(80);
		chk(leds(), {6'h20, 6'h00, 16'h0002, 16'h8001}, "memories");
		press(20);
		apb(0, A_STATUS, 0);
		chk(r[2:0], 3'h5, "menu kept");
		press(80);
		for (int k = 0; k < 4; k++)
		begin
			bus_rate <= 2'(k);
			repeat (3) @(posedge sys_clk);
			chk(leds(), {6'h20, 6'h20, 16'h0000,
				(k < 3) ? 16'(1 << k) : 16'h0000}, "rate");
		end
		press(80);
		chk({menu_red, menu_green}, {6'h00, 6'h20}, "back");
	endtask : t_bus_menu

	task automatic t_config();
		logic [2:0] m;
		apb(0, A_STATUS, 0);
		m = r[2:0];
		apb(1, A_CTRL, 32'h0000_0010);
		repeat (3) @(posedge sys_clk);
		chk(leds(), {6'h3F, 6'h3F, 16'h0001, 16'h0001}, "config");
		press(20);
		apb(0, A_STATUS, 0);
		chk(r[2:0], m, "locked");
		apb(1, A_CTRL, 32'h0000_0000);
	endtask : t_config

	task automatic t_fatal();
		logic [15:0] tbl [7];
		tbl = '{16'h0002, 16'h0009, 16'h000A, 16'h000F, 16'h0100,
			16'h0102, 16'hC0FF};
		for (int k = 0; k < 7; k++)
		begin
			do_reset();
			apb(1, A_INT_MASK, 32'h0000_0004);
			if (k < 6)
				fault_v <= 6'h01 << k;
			else
			begin
				apb(1, A_USER_ERR, 32'h0000_0000);
				chk(io_off, 1'b0, "zero ignored");
				apb(1, A_USER_ERR, 32'h0000_00FF);
			end
			repeat (4) @(posedge sys_clk);
			chk(leds(), {6'h3F, 6'h00, tbl[k], 16'h0000}, "pattern");
			chk({io_off, comm_stop, irq}, 3'b111, "stopped");
			fault_v <= 6'h3F;
			press(20);
			apb(0, A_CODE, 0);
			chk(r[15:0], tbl[k], "code");
			apb(0, A_STATUS, 0);
			chk({r[16], r[2:0]}, 4'h8, "locked");
			fault_v <= 6'h00;
		end
		do_reset();
	endtask : t_fatal

	task automatic t_unmapped();
		apb(0, 8'h18, 0);
		chk({e, r}, {1'b1, 32'h0000_0000}, "unmapped");
	endtask : t_unmapped

	task automatic t_idle();
		repeat (3) press(20);
		repeat (2) press(80);
		chk({menu_red, menu_green}, {6'h04, 6'h04}, "volt third");
		apb(1, A_INT_STAT, 32'h0000_000F);
		repeat (2100) @(posedge sys_clk);
		chk({menu_red, menu_green}, {6'h00, 6'h01}, "idle home");
		apb(0, A_INT_STAT, 0);
		chk(r[3], 1'b1, "idle event");
	endtask : t_idle

	initial
	begin
		do_reset();
		t_reset_state();
		t_menu_cycle();
		t_two_level();
		t_bus_menu();
		t_config();
		t_unmapped();
		t_idle();
		t_fatal();
		wrap_up();
	end
endmodule : lsm_display_tb
